// ### design/dcil_top.sv
// Purpose: DC input on/off interlock, event actions and alarm handling
// Assumes: pins asynchronous; software over AXI4-Lite
// Notes:   ACK by pin needs a low of at least the ack time
// What this block does
// - remote mode: standby pin alone sets DC
// - polarity setting inverts standby pin meaning
// - open standby pin reads high, means on
// - entering remote with on request switches on
// - local, off, unlocked level: commands may switch on
// - local, off, lock level: switch-on refused
// - refused switch-on raises error indication
// - local, on, unlocked: stays on, switchable
// - local, on, pin locks: switch off, lock
// - pin unlock restores, unless request cancelled
// - command during pin lock cancels restore
// - local pin never switches on from off
// - event actions NONE, SIGNAL, WARNING
// - ALARM action: text, popup, sound, DC off
// - device alarm: DC off, popup, sound
// - alarm pending until acknowledged
// - indication clears after cause and ack
// - status area select reopens alarm popup
// - events evaluated only while DC on
// - remote pin low selects remote
`timescale 1ns/1ps
`default_nettype none
`include "dcil_consts.svh"
module dcil_top #(
    parameter int ACK_CYCLES = `DCIL_ACK_CYCLES  // ack low time
) (
    input  wire logic        clock,          // 250 MHz clock
    input  wire logic        rst_b,          // async reset, active low
    input  wire logic        standbyLockPin, // standby pin level
    input  wire logic        remoteSelPin,   // remote select pin level
    input  wire logic        buttonPress,    // front button pulse
    input  wire logic        statusSelect,   // status area tapped, pulse
    input  wire logic [2:0]  eventHit,       // user event conditions
    input  wire logic [3:0]  alarmCond,      // device alarm conditions
    input  wire logic        s_axi_awvalid,  // AXI write address valid
    output logic             s_axi_awready,  // AXI write address ready
    input  wire logic [3:0]  s_axi_awaddr,   // AXI write address
    input  wire logic        s_axi_wvalid,   // AXI write data valid
    output logic             s_axi_wready,   // AXI write data ready
    input  wire logic [31:0] s_axi_wdata,    // AXI write data
    input  wire logic [3:0]  s_axi_wstrb,    // AXI write strobes
    output logic             s_axi_bvalid,   // AXI write response valid
    input  wire logic        s_axi_bready,   // AXI write response ready
    output logic [1:0]       s_axi_bresp,    // AXI write response
    input  wire logic        s_axi_arvalid,  // AXI read address valid
    output logic             s_axi_arready,  // AXI read address ready
    input  wire logic [3:0]  s_axi_araddr,   // AXI read address
    output logic             s_axi_rvalid,   // AXI read data valid
    input  wire logic        s_axi_rready,   // AXI read data ready
    output logic [31:0]      s_axi_rdata,    // AXI read data
    output logic [1:0]       s_axi_rresp,    // AXI read response
    output logic             dcInputOn,      // DC input switched on
    output logic             lockErrorPopup, // refused switch-on, pulse
    output logic             alarmPopup,     // alarm popup shown
    output logic             warnPopup,      // warning popup shown
    output logic             statusText,     // status text shown
    output logic             soundOn         // acoustic signal
);
    import dcil_pkg::*;

    localparam int DEB = `DCIL_DEB_CYCLES;
    localparam int NE  = `DCIL_NUM_EVENTS;
    localparam int NA  = `DCIL_NUM_ALARMS;

    logic [1:0]  sbSync_r;
    logic [1:0]  remSync_r;
    logic        sbDeb_r;
    logic        remDeb_r;
    logic [11:0] sbCnt_r;
    logic [11:0] remCnt_r;
    logic        remoteAct_r;
    logic        invertPol_r;
    logic        soundEn_r;
    logic [5:0]  eventAct_r;
    logic        digOn_r;
    logic        digOff_r;
    dcil_state_t state_r;
    logic        onReq;
    logic        offReq;
    logic        sbWantOn;
    logic [NA-1:0] alarmPend_r;
    logic [NA-1:0] alarmAcked_r;
    logic        ackPulse;
    logic        swAck_r;
    logic [27:0] lowCnt_r;
    logic        lowLong_r;
    logic        sbPrev_r;
    logic [NE-1:0] evtAlarm;
    logic [NE-1:0] evtWarn;
    logic [NE-1:0] evtSig;
    logic        tripOff;
    logic        evtLatch_r;
    logic        wrAddrHeld_r;
    logic        wrDataHeld_r;
    logic [3:0]  wrAddr_r;
    logic [31:0] wrData_r;
    logic        wrGo;

    // two-stage synchronisers, first stage read only by second
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sbSync_r  <= 2'b11;
            remSync_r <= 2'b11;
        end else begin
            sbSync_r  <= {sbSync_r[0], standbyLockPin};
            remSync_r <= {remSync_r[0], remoteSelPin};
        end
    end

    // debounce: level must stay stable for DEB cycles
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sbDeb_r  <= 1'b1;
            remDeb_r <= 1'b1;
            sbCnt_r  <= 12'h000;
            remCnt_r <= 12'h000;
        end else begin
            if (sbSync_r[1] == sbDeb_r) begin
                sbCnt_r <= 12'h000;
            end else if (sbCnt_r == 12'(DEB - 1)) begin
                sbDeb_r <= sbSync_r[1];
                sbCnt_r <= 12'h000;
            end else begin
                sbCnt_r <= sbCnt_r + 12'h001;
            end
            if (remSync_r[1] == remDeb_r) begin
                remCnt_r <= 12'h000;
            end else if (remCnt_r == 12'(DEB - 1)) begin
                remDeb_r <= remSync_r[1];
                remCnt_r <= 12'h000;
            end else begin
                remCnt_r <= remCnt_r + 12'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            remoteAct_r <= 1'b0;
        end else begin
            remoteAct_r <= ~remDeb_r;
        end
    end

    assign sbWantOn = sbDeb_r ^ invertPol_r;
    assign onReq    = (buttonPress & ~dcInputOn) | digOn_r;
    assign offReq   = (buttonPress & dcInputOn) | digOff_r;

    // user events, only while DC on
    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : gEvt
            logic hit;
            assign hit = eventHit[g] & dcInputOn;
            assign evtSig[g] =
                hit & (eventAct_r[2*g+:2] != DCIL_ACT_NONE);
            assign evtWarn[g] =
                hit & (eventAct_r[2*g+:2] == DCIL_ACT_WARNING);
            assign evtAlarm[g] =
                hit & (eventAct_r[2*g+:2] == DCIL_ACT_ALARM);
        end
    endgenerate

    assign tripOff = (|evtAlarm) | (|(alarmCond & ~alarmAcked_r));

    // DC input state machine
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= DCIL_ST_OFF;
        end else if (tripOff) begin
            state_r <= DCIL_ST_OFF;
        end else if (remoteAct_r) begin
            state_r <= sbWantOn ? DCIL_ST_ON : DCIL_ST_OFF;
        end else begin
            case (state_r)
                DCIL_ST_OFF: begin
                    if (onReq && sbWantOn) begin
                        state_r <= DCIL_ST_ON;
                    end
                end
                DCIL_ST_ON: begin
                    if (!sbWantOn) begin
                        state_r <= DCIL_ST_PINOFF;
                    end else if (offReq) begin
                        state_r <= DCIL_ST_OFF;
                    end
                end
                DCIL_ST_PINOFF: begin
                    if (onReq || offReq) begin
                        state_r <= DCIL_ST_OFF;
                    end else if (sbWantOn) begin
                        state_r <= DCIL_ST_ON;
                    end
                end
                default: state_r <= DCIL_ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dcInputOn      <= 1'b0;
            lockErrorPopup <= 1'b0;
        end else begin
            dcInputOn      <= (state_r == DCIL_ST_ON);
            lockErrorPopup <= ~remoteAct_r & onReq & ~sbWantOn &
                              (state_r != DCIL_ST_ON);
        end
    end

    // remote ack: long enough low then back high
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt_r  <= 28'h000_0000;
            lowLong_r <= 1'b0;
            sbPrev_r  <= 1'b1;
        end else begin
            sbPrev_r <= sbWantOn;
            if (sbWantOn) begin
                lowCnt_r  <= 28'h000_0000;
                lowLong_r <= 1'b0;
            end else if (lowCnt_r == 28'(ACK_CYCLES - 1)) begin
                lowLong_r <= 1'b1;
            end else begin
                lowCnt_r <= lowCnt_r + 28'h000_0001;
            end
        end
    end
    assign ackPulse = swAck_r |
        (remoteAct_r & lowLong_r & sbWantOn & ~sbPrev_r);

    // alarms: pending until ack; persistent cause needs re-ack
    generate
        for (g = 0; g < NA; g++) begin : gAlm
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    alarmPend_r[g]  <= 1'b0;
                    alarmAcked_r[g] <= 1'b0;
                end else begin
                    if (alarmCond[g] && !alarmAcked_r[g]) begin
                        alarmPend_r[g] <= 1'b1;
                    end else if (ackPulse) begin
                        alarmPend_r[g] <= 1'b0;
                    end
                    if (!alarmCond[g]) begin
                        alarmAcked_r[g] <= 1'b0;
                    end else if (ackPulse && alarmPend_r[g]) begin
                        alarmAcked_r[g] <= 1'b1;
                    end else if (statusSelect) begin
                        alarmAcked_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alarmPopup <= 1'b0;
            warnPopup  <= 1'b0;
            statusText <= 1'b0;
            soundOn    <= 1'b0;
            evtLatch_r <= 1'b0;
        end else begin
            // an alarm event clears its own cause by tripping, so hold it
            evtLatch_r <= (|evtAlarm) | (evtLatch_r & ~ackPulse);
            alarmPopup <= (|(alarmPend_r & ~alarmAcked_r)) | evtLatch_r;
            warnPopup  <= |evtWarn;
            statusText <= (|evtSig) | evtLatch_r | (|alarmPend_r) |
                (|alarmAcked_r);
            soundOn    <= soundEn_r &
                ((|(alarmPend_r & ~alarmAcked_r)) | evtLatch_r);
        end
    end

    // AXI4-Lite slave; one write and one read outstanding
    assign wrGo = wrAddrHeld_r & wrDataHeld_r & ~s_axi_bvalid;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrAddrHeld_r <= 1'b0;
            wrDataHeld_r <= 1'b0;
            wrAddr_r     <= 4'h0;
            wrData_r     <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= ~wrAddrHeld_r & ~s_axi_awready;
            s_axi_wready  <= ~wrDataHeld_r & ~s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                wrAddrHeld_r <= 1'b1;
                wrAddr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wrDataHeld_r <= 1'b1;
                wrData_r     <= s_axi_wdata;
                s_axi_wready  <= 1'b0;
            end
            if (wrGo) begin
                wrAddrHeld_r <= 1'b0;
                wrDataHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wrAddr_r[3:2] == 2'h1) ? 2'h2 : 2'h0;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            invertPol_r <= 1'b0;
            soundEn_r   <= 1'b0;
            eventAct_r  <= 6'h00;
            digOn_r     <= 1'b0;
            digOff_r    <= 1'b0;
            swAck_r     <= 1'b0;
        end else begin
            digOn_r  <= 1'b0;
            digOff_r <= 1'b0;
            swAck_r  <= 1'b0;
            if (wrGo && wrAddr_r == `DCIL_OFF_CTRL && wrData_r[0]) begin
                invertPol_r <= wrData_r[1];
                soundEn_r   <= wrData_r[2];
                eventAct_r  <= wrData_r[9:4];
            end
            if (wrGo && wrAddr_r == `DCIL_OFF_CMD) begin
                digOn_r  <= wrData_r[0] & ~remoteAct_r;
                digOff_r <= wrData_r[1] & ~remoteAct_r;
            end
            if (wrGo && wrAddr_r == `DCIL_OFF_ALARM) begin
                swAck_r <= wrData_r[0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                case (s_axi_araddr)
                    `DCIL_OFF_CTRL: s_axi_rdata <= {22'h00_0000,
                        eventAct_r, 1'b0, soundEn_r, invertPol_r, 1'b0};
                    `DCIL_OFF_STAT: s_axi_rdata <= {16'h0000,
                        alarmAcked_r, alarmPend_r, 3'h0, remoteAct_r,
                        sbDeb_r, state_r, dcInputOn};
                    `DCIL_OFF_CMD:   s_axi_rdata <= 32'h0000_0000;
                    `DCIL_OFF_ALARM: s_axi_rdata <= {28'h000_0000,
                        alarmPend_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_remote_pin_rules: assert property (@(posedge clock) disable iff (!rst_b)
        (remoteAct_r && !tripOff) |=> (state_r == ($past(sbWantOn) ?
        DCIL_ST_ON : DCIL_ST_OFF)))
        else $error("remote state not from pin");
    a_lock_refuses_on: assert property (@(posedge clock) disable iff (!rst_b)
        (!remoteAct_r && state_r == DCIL_ST_OFF && !sbWantOn)
        |=> state_r != DCIL_ST_ON) else $error("locked input switched on");
    a_lock_error_pulse: assert property (@(posedge clock) disable iff (!rst_b)
        (!remoteAct_r && onReq && !sbWantOn && state_r == DCIL_ST_OFF)
        |=> lockErrorPopup) else $error("no error on refused on");
    a_pin_switch_off: assert property (@(posedge clock) disable iff (!rst_b)
        (!remoteAct_r && !tripOff && state_r == DCIL_ST_ON && !sbWantOn)
        |=> state_r == DCIL_ST_PINOFF) else $error("pin lock not off");
    a_pin_restore_on: assert property (@(posedge clock) disable iff (!rst_b)
        (!remoteAct_r && !tripOff && state_r == DCIL_ST_PINOFF && sbWantOn
        && !onReq && !offReq) |=> ##1 dcInputOn)
        else $error("pin restore failed");
    a_cancel_restore: assert property (@(posedge clock) disable iff (!rst_b)
        (!remoteAct_r && !tripOff && state_r == DCIL_ST_PINOFF && buttonPress)
        |=> state_r == DCIL_ST_OFF) else $error("restore not cancelled");
    a_alarm_trips_off: assert property (@(posedge clock) disable iff (!rst_b)
        tripOff |=> ##1 !dcInputOn) else $error("alarm left DC on");
    a_alarm_stays_pend: assert property (@(posedge clock) disable iff (!rst_b)
        (alarmPend_r[0] && !ackPulse) |=> alarmPend_r[0])
        else $error("alarm dropped without ack");
    a_event_needs_on: assert property (@(posedge clock) disable iff (!rst_b)
        !dcInputOn |-> evtSig == 3'h0) else $error("event while off");
    c_pin_lock: cover property (@(posedge clock) disable iff (!rst_b)
        state_r == DCIL_ST_ON ##1 state_r == DCIL_ST_PINOFF);
    c_refused: cover property (@(posedge clock) disable iff (!rst_b)
        lockErrorPopup);
    c_remote_on: cover property (@(posedge clock) disable iff (!rst_b)
        remoteAct_r && dcInputOn);
endmodule
`default_nettype wire

// ### shared/dcil_consts.svh
// Purpose: constants of the DC input interlock controller
// Assumes: 250 MHz clock
// Notes:   register offsets are byte addresses on AXI4-Lite
`ifndef DCIL_CONSTS_SVH
`define DCIL_CONSTS_SVH
`define DCIL_CLK_MHZ        250
`define DCIL_DEBOUNCE_US    5
`define DCIL_DEB_CYCLES     (`DCIL_DEBOUNCE_US * `DCIL_CLK_MHZ)
`define DCIL_ACK_LOW_MS     50
`define DCIL_ACK_CYCLES     (`DCIL_ACK_LOW_MS * 1000 * `DCIL_CLK_MHZ)
`define DCIL_OFF_CTRL       4'h0
`define DCIL_OFF_STAT       4'h4
`define DCIL_OFF_CMD        4'h8
`define DCIL_OFF_ALARM      4'hC
`define DCIL_CTRL_RESET     32'h0000_0000
`define DCIL_NUM_EVENTS     3
`define DCIL_NUM_ALARMS     4
`endif

// ### shared/dcil_pkg.sv
// Purpose: types of the DC input interlock controller
// Assumes: nothing
// Notes:   event action encoding
package dcil_pkg;
    typedef enum logic [1:0] {
        DCIL_ACT_NONE    = 2'h0,
        DCIL_ACT_SIGNAL  = 2'h1,
        DCIL_ACT_WARNING = 2'h2,
        DCIL_ACT_ALARM   = 2'h3
    } dcil_action_t;
    typedef enum logic [1:0] {
        DCIL_ST_OFF    = 2'b00,
        DCIL_ST_ON     = 2'b01,
        DCIL_ST_PINOFF = 2'b11
    } dcil_state_t;
endpackage

// ### test/dcil_pin_model.sv
// Purpose: external contacts on the standby and remote select pins
// Assumes: open-collector contacts to ground, pins pulled up inside
// Notes:   every standby change bounces for a few cycles first
`timescale 1ns/1ps
`default_nettype none
module dcil_pin_model (
    input  wire logic clock,          // bench clock
    input  wire logic closeStby,      // standby contact closed
    input  wire logic closeRem,       // remote contact closed
    output logic      standbyLockPin, // standby pin level
    output logic      remoteSelPin    // remote select pin level
);
    logic       stbyLast;
    logic [2:0] bounceCnt;
    initial begin
        stbyLast  = 1'b0;
        bounceCnt = 3'h0;
    end
    // an open contact leaves the pull-up in charge
    always_comb remoteSelPin = ~closeRem;
    always_comb begin
        // bounce flips the level each cycle, so a slack debounce shows
        if (bounceCnt != 3'h0) begin
            standbyLockPin = bounceCnt[0];
        end else begin
            standbyLockPin = ~closeStby;
        end
    end
    always @(posedge clock) begin
        if (closeStby != stbyLast) begin
            bounceCnt <= 3'h6;
        end else if (bounceCnt != 3'h0) begin
            bounceCnt <= bounceCnt - 3'h1;
        end
        stbyLast <= closeStby;
    end
endmodule
`default_nettype wire

// ### test/dcil_top_bench.sv
// Purpose: self-checking bench of the DC input interlock controller
// Assumes: pin debounce of 1250 cycles, short ack time in simulation
// Notes:   pin waits are generous since debounce dominates latency
`timescale 1ns/1ps
`default_nettype none
`include "dcil_consts.svh"
module dcil_top_bench;
    import dcil_pkg::*;
    localparam int ACK = 20;
    localparam int PIN = 1400;
    logic        clock, rst_b, closeStby, closeRem, buttonPress;
    logic        statusSelect, standbyLockPin, remoteSelPin, sawErr;
    logic [2:0]  eventHit;
    logic [3:0]  alarmCond, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic        dcInputOn, lockErrorPopup, alarmPopup, warnPopup;
    logic        statusText, soundOn;
    int          errors, compares, seed, k, j;
    initial begin
        clock = 1'b0; rst_b = 1'b0; closeStby = 1'b0; closeRem = 1'b0;
        buttonPress = 1'b0; statusSelect = 1'b0; eventHit = 3'h0;
        alarmCond = 4'h0; s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0;
        s_axi_wstrb = 4'hF; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
        s_axi_wdata = 32'h0000_0000; sawErr = 1'b0;
        errors = 0; compares = 0; seed = 27505;
    end
    always #2 clock = ~clock;
    dcil_pin_model i_dcil_pin_model (.clock(clock), .closeStby(closeStby),
        .closeRem(closeRem), .standbyLockPin(standbyLockPin),
        .remoteSelPin(remoteSelPin));
    dcil_top #(.ACK_CYCLES(ACK)) i_dcil_top (.clock(clock), .rst_b(rst_b),
        .standbyLockPin(standbyLockPin), .remoteSelPin(remoteSelPin),
        .buttonPress(buttonPress), .statusSelect(statusSelect),
        .eventHit(eventHit), .alarmCond(alarmCond),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .dcInputOn(dcInputOn),
        .lockErrorPopup(lockErrorPopup), .alarmPopup(alarmPopup),
        .warnPopup(warnPopup), .statusText(statusText), .soundOn(soundOn));
    // the error output is a one-cycle pulse, so it is caught here
    always @(posedge clock) if (lockErrorPopup === 1'b1) sawErr <= 1'b1;
    task automatic end_sim();
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic axiWr(input logic [3:0] a, input logic [31:0] d,
                         input logic [1:0] expResp);
        int n;
        logic [1:0] resp;
        n = 0;
        resp = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 200) begin
            @(posedge clock);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
                resp = s_axi_bresp;
                n = 1000;
            end
        end
        check("bresp", expResp, resp);
    endtask
    task automatic axiRd(input logic [3:0] a, output logic [31:0] d,
                         input logic [1:0] expResp);
        int n;
        logic [1:0] resp;
        n = 0;
        resp = 2'h3;
        d = 32'hFFFF_FFFF;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 200) begin
            @(posedge clock);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
                resp = s_axi_rresp;
                d = s_axi_rdata;
                n = 1000;
            end
        end
        check("rresp", expResp, resp);
    endtask
    task automatic press();
        buttonPress <= 1'b1;
        cyc(1);
        buttonPress <= 1'b0;
        cyc(1);
    endtask
    task automatic waitDc(input logic exp, input int lim);
        int n;
        n = 0;
        while (dcInputOn !== exp && n < lim) begin
            cyc(1);
            n++;
        end
        check("dcInputOn", exp, dcInputOn);
    endtask
    initial begin
        cyc(90000);
        errors++;
        end_sim();
    end
    initial begin
        cyc(12);
        check("dcInputOn in reset", 1'b0, dcInputOn);
        rst_b <= 1'b1;
        cyc(2);
        axiRd(`DCIL_OFF_STAT, rd, 2'h0);
        check("stat dc bit", 1'b0, rd[0]);
        axiWr(`DCIL_OFF_STAT, 32'h0000_0001, 2'h2);
        axiRd(4'h2, rd, 2'h2);
        check("unmapped data", 32'h0000_0000, rd);
        axiWr(`DCIL_OFF_CTRL, 32'h0000_0001, 2'h0);
        cyc(PIN);
        check("open pin no switch-on", 1'b0, dcInputOn);
        axiWr(`DCIL_OFF_CMD, 32'h0000_0001, 2'h0);
        waitDc(1'b1, 20);
        press();
        waitDc(1'b0, 20);
        press();
        waitDc(1'b1, 20);
        closeStby <= 1'b1;
        cyc(100);
        closeStby <= 1'b0;
        cyc(PIN);
        check("glitch ignored", 1'b1, dcInputOn);
        closeStby <= 1'b1;
        waitDc(1'b0, PIN);
        closeStby <= 1'b0;
        waitDc(1'b1, PIN);
        closeStby <= 1'b1;
        waitDc(1'b0, PIN);
        press();
        cyc(10);
        closeStby <= 1'b0;
        cyc(PIN);
        check("cancelled restore", 1'b0, dcInputOn);
        closeStby <= 1'b1;
        cyc(PIN);
        sawErr <= 1'b0;
        axiWr(`DCIL_OFF_CMD, 32'h0000_0001, 2'h0);
        cyc(10);
        check("command refused", {1'b1, 1'b0}, {sawErr, dcInputOn});
        sawErr <= 1'b0;
        press();
        cyc(10);
        check("button refused", {1'b1, 1'b0}, {sawErr, dcInputOn});
        axiWr(`DCIL_OFF_CTRL, 32'h0000_0003, 2'h0);
        cyc(5);
        axiWr(`DCIL_OFF_CMD, 32'h0000_0001, 2'h0);
        waitDc(1'b1, 20);
        closeStby <= 1'b0;
        waitDc(1'b0, PIN);
        closeStby <= 1'b1;
        waitDc(1'b1, PIN);
        axiWr(`DCIL_OFF_CMD, 32'h0000_0002, 2'h0);
        waitDc(1'b0, 20);
        axiWr(`DCIL_OFF_CTRL, 32'h0000_0001, 2'h0);
        closeStby <= 1'b0;
        cyc(PIN);
        closeRem <= 1'b1;
        waitDc(1'b1, PIN);
        axiWr(`DCIL_OFF_CMD, 32'h0000_0002, 2'h0);
        press();
        cyc(10);
        check("remote ignores commands", 1'b1, dcInputOn);
        closeStby <= 1'b1;
        waitDc(1'b0, PIN);
        closeStby <= 1'b0;
        waitDc(1'b1, PIN);
        closeRem <= 1'b0;
        cyc(PIN);
        // each action once, on an event picked at random
        for (int a = 0; a < 4; a++) begin
            k = {$random(seed)} % 3;
            axiWr(`DCIL_OFF_CTRL, 32'h0000_0005 | (a << (4 + 2 * k)), 2'h0);
            axiWr(`DCIL_OFF_CMD, 32'h0000_0001, 2'h0);
            waitDc(1'b1, 20);
            eventHit[k] <= 1'b1;
            cyc(10);
            check("statusText", a != 0, statusText);
            check("warnPopup", a == 2, warnPopup);
            check("alarm, sound, dc", {a == 3, a == 3, a != 3},
                  {alarmPopup, soundOn, dcInputOn});
            eventHit[k] <= 1'b0;
            cyc(5);
            axiWr(`DCIL_OFF_ALARM, 32'h0000_0001, 2'h0);
        end
        axiWr(`DCIL_OFF_CTRL, 32'h0000_0015, 2'h0);
        eventHit[0] <= 1'b1;
        cyc(10);
        check("no event while off", 1'b0, statusText);
        eventHit[0] <= 1'b0;
        axiWr(`DCIL_OFF_CMD, 32'h0000_0001, 2'h0);
        waitDc(1'b1, 20);
        j = {$random(seed)} % 4;
        alarmCond[j] <= 1'b1;
        waitDc(1'b0, 20);
        check("alarm popup, sound", 2'h3, {alarmPopup, soundOn});
        axiWr(`DCIL_OFF_ALARM, 32'h0000_0001, 2'h0);
        axiRd(`DCIL_OFF_ALARM, rd, 2'h0);
        check("pending after early ack", 2'h2, {rd[j], alarmPopup});
        statusSelect <= 1'b1;
        cyc(1);
        statusSelect <= 1'b0;
        cyc(5);
        check("popup reopened", 1'b1, alarmPopup);
        alarmCond[j] <= 1'b0;
        cyc(5);
        axiRd(`DCIL_OFF_ALARM, rd, 2'h0);
        check("pending until ack", 1'b1, rd[j]);
        axiWr(`DCIL_OFF_ALARM, 32'h0000_0001, 2'h0);
        cyc(5);
        axiRd(`DCIL_OFF_ALARM, rd, 2'h0);
        check("cleared by ack", {4'h0, 1'b0}, {rd[3:0], alarmPopup});
        alarmCond[j] <= 1'b1;
        cyc(5);
        alarmCond[j] <= 1'b0;
        closeRem <= 1'b1;
        cyc(PIN);
        closeStby <= 1'b1;
        cyc(PIN + ACK);
        closeStby <= 1'b0;
        cyc(PIN);
        axiRd(`DCIL_OFF_ALARM, rd, 2'h0);
        check("pin ack", 4'h0, rd[3:0]);
        end_sim();
    end
endmodule
`default_nettype wire
